// ===== hdl/watchdog_timer.v
// watchdog timer: low-frequency tick divider, period counter, sleep handling, registers
// How it works
// - Awake time-out with no clear pulses the system reset output.
// - Count advances only on the low-frequency oscillator tick, not system clock.
// - Mode code 00 keeps the watchdog off regardless of software enable.
// - Mode code 11 runs awake and asleep, ignoring software enable.
// - Mode code 10 runs awake, off in sleep, ignoring software enable.
// - Mode code 01 runs exactly when software enable is one.
// - Period select code n gives a ratio of two to the power five plus n.
// - Codes 10011 to 11111 act as the minimum ratio of 1:32.
// - Any reset returns period select to 01011, ratio 1:65536.
// - Count zeroed on reset, clear, sleep entry, exit, osc fail, disable.
// - Changing the internal oscillator divider leaves the count alone.
// - Sleep entry clears count; counting restarts in sleep if enabled; exit clears.
// - Time-out in sleep wakes the device, clears the time-out and watchdog reset flags, gives no reset.
// - Power control register holds a readable watchdog reset flag.
// - Control: period select bits 5..1, enable bit 0, bits 7..6 read zero.
// - Sleep instruction sets the time-out flag and clears the power-down flag.
`include "watchdog_timer_map.vh"
`timescale 1ns/100ps
`default_nettype none

module watchdog_timer #(
   parameter integer TICK_CYCLES = `WDT_TICK_CYCLES,
   parameter integer CNT_W       = 23
) (
   // clock and reset
   input  wire        I_CLK_SYS,
   input  wire        I_SRST,
   // register port
   input  wire [3:0]  I_ADDR,
   input  wire [7:0]  I_WDATA,
   input  wire        I_WR,
   input  wire        I_RD,
   output reg  [7:0]  O_RDATA,
   // configuration and system events
   input  wire [1:0]  I_WATCHDOG_MODE_SELECT,
   input  wire        I_WATCHDOG_CLEAR_INSTRUCTION,
   input  wire        I_SLEEP_INSTRUCTION,
   input  wire        I_WAKE_EVENT,
   input  wire        I_OSC_FAIL,
   input  wire [3:0]  I_INTERNAL_OSC_DIVIDER,
   // watchdog outputs
   output reg         O_WDT_RESET,
   output reg         O_WDT_WAKE,
   output wire        O_ASLEEP
);

   // divider to the nominal low-frequency tick
   localparam integer TW = 16;

   reg  [TW-1:0]    tick_cnt_r;
   reg              tick_r;
   reg  [CNT_W-1:0] count_r;
   reg  [4:0]       period_select_r;
   reg              sw_watchdog_enable_r;
   reg              asleep_r;
   reg              timeout_status_flag_r;
   reg              powerdown_status_flag_r;
   reg              watchdog_reset_flag_r;
   reg  [CNT_W-1:0] count_nxt;
   reg              active;
   reg              expire;

   wire cmd_wr       = I_WR && (I_ADDR == `WDT_ADDR_CMD);
   wire clear_cmd    = I_WATCHDOG_CLEAR_INSTRUCTION ||
                       (cmd_wr && I_WDATA[`WDT_CMD_CLEAR_BIT]);
   wire sleep_cmd    = (I_SLEEP_INSTRUCTION ||
                       (cmd_wr && I_WDATA[`WDT_CMD_SLEEP_BIT])) && !asleep_r;
   wire wake         = asleep_r && (I_WAKE_EVENT || expire);

   // terminal count minus one for a select code; reserved codes fold to the minimum
   function [CNT_W-1:0] limit_of;
      input [4:0] ps;
      reg   [4:0] eff;
      begin
         eff = (ps > `WDT_PS_MAX_VALID) ? 5'h00 : ps;
         limit_of = ({{(CNT_W-1){1'b0}}, 1'b1} << (eff + `WDT_PRESCALE_LSB)) - 1'b1;
      end
   endfunction

   // tick divider; the internal oscillator divider input is deliberately unused here
   always @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         tick_cnt_r <= 16'h0000;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == TICK_CYCLES[TW-1:0] - 1'b1) begin
         tick_cnt_r <= 16'h0000;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
         tick_r     <= 1'b0;
      end
   end

   // enable per mode and sleep state
   always @* begin
      case (I_WATCHDOG_MODE_SELECT)
         `WDT_MODE_OFF:      active = 1'b0;
         `WDT_MODE_SOFTWARE: active = sw_watchdog_enable_r;
         `WDT_MODE_NO_SLEEP: active = !asleep_r;
         `WDT_MODE_ALWAYS:   active = 1'b1;
         default:            active = 1'b0;
      endcase
      expire = active && tick_r && (count_r == limit_of(period_select_r));
   end

   // period counter; divider changes are not a clearing condition
   always @* begin
      if (!active || clear_cmd || sleep_cmd || wake || I_OSC_FAIL || expire)
         count_nxt = {CNT_W{1'b0}};
      else if (tick_r)
         count_nxt = count_r + 1'b1;
      else
         count_nxt = count_r;
   end

   always @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         count_r <= {CNT_W{1'b0}};
         O_WDT_RESET <= 1'b0;
         O_WDT_WAKE  <= 1'b0;
         asleep_r    <= 1'b0;
      end else begin
         count_r     <= count_nxt;
         O_WDT_RESET <= expire && !asleep_r;
         O_WDT_WAKE  <= expire && asleep_r;
         if (sleep_cmd)
            asleep_r <= 1'b1;
         else if (wake)
            asleep_r <= 1'b0;
      end
   end

   // status flags; time-out flag is active low, cleared by a sleep-time expiry
   always @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         period_select_r         <= `WDT_PS_RESET;
         sw_watchdog_enable_r    <= 1'b0;
         timeout_status_flag_r   <= 1'b1;
         powerdown_status_flag_r <= 1'b1;
         watchdog_reset_flag_r   <= 1'b1;
      end else begin
         if (I_WR && I_ADDR == `WDT_ADDR_CONTROL) begin
            period_select_r      <= I_WDATA[`WDT_CTRL_PS_MSB:`WDT_CTRL_PS_LSB];
            sw_watchdog_enable_r <= I_WDATA[`WDT_CTRL_EN_BIT];
         end
         if (sleep_cmd) begin
            timeout_status_flag_r   <= 1'b1;
            powerdown_status_flag_r <= 1'b0;
         end else if (expire && asleep_r) begin
            timeout_status_flag_r   <= 1'b0;
         end
         // hardware event beats a software set in the same cycle
         if (expire)
            watchdog_reset_flag_r <= 1'b0;
         else if (cmd_wr && I_WDATA[`WDT_CMD_WATCHDOG_RESET_FLAG_SET_BIT])
            watchdog_reset_flag_r <= 1'b1;
      end
   end

   // read port, data one cycle after the strobe
   always @(posedge I_CLK_SYS) begin
      if (I_SRST)
         O_RDATA <= 8'h00;
      else if (I_RD) begin
         case (I_ADDR)
            `WDT_ADDR_CONTROL:
               O_RDATA <= {2'b00, period_select_r, sw_watchdog_enable_r};
            `WDT_ADDR_STATUS:
               O_RDATA <= {3'b000, timeout_status_flag_r, powerdown_status_flag_r, 3'b000};
            `WDT_ADDR_POWER_CTRL:
               O_RDATA <= {3'b000, watchdog_reset_flag_r, 4'h0};
            default:
               O_RDATA <= 8'h00;
         endcase
      end else
         O_RDATA <= 8'h00;
   end

   assign O_ASLEEP = asleep_r;

endmodule
`default_nettype wire

// ===== hdl/watchdog_timer_map.vh
// register map, field positions, reset values and timing counts of the watchdog timer
`ifndef WATCHDOG_TIMER_MAP_VH
`define WATCHDOG_TIMER_MAP_VH

// register addresses (port offsets)
`define WDT_ADDR_CONTROL      4'h0
`define WDT_ADDR_STATUS       4'h1
`define WDT_ADDR_POWER_CTRL   4'h2
`define WDT_ADDR_CMD          4'h3

// control register fields
`define WDT_CTRL_EN_BIT       0
`define WDT_CTRL_PS_LSB       1
`define WDT_CTRL_PS_MSB       5
`define WDT_CTRL_RESET        8'h16
`define WDT_PS_RESET          5'h0B
`define WDT_PS_MAX_VALID      5'h12

// status register fields
`define WDT_STAT_PD_BIT       3
`define WDT_STAT_TO_BIT       4

// power control register fields
`define WDT_POWER_CONTROL_REG_WATCHDOG_RESET_FLAG_BIT     4

// command register fields (write-one pulses)
`define WDT_CMD_CLEAR_BIT     0
`define WDT_CMD_SLEEP_BIT     1
`define WDT_CMD_WATCHDOG_RESET_FLAG_SET_BIT  2

// mode field codes
`define WDT_MODE_OFF          2'h0
`define WDT_MODE_SOFTWARE     2'h1
`define WDT_MODE_NO_SLEEP     2'h2
`define WDT_MODE_ALWAYS       2'h3

// timing: low-frequency oscillator tick
`define WDT_LFOSC_HZ          31000
`define WDT_SYS_HZ            100000000
`define WDT_TICK_CYCLES       (`WDT_SYS_HZ / `WDT_LFOSC_HZ)
`define WDT_PRESCALE_LSB      5

`endif

// ===== dv/watchdog_timer_asserts.sv
// port-level assertions for the watchdog timer
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_asserts (
   // clock and reset
   input wire logic       I_CLK_SYS,
   input wire logic       I_SRST,
   // register port
   input wire logic [3:0] I_ADDR,
   input wire logic       I_RD,
   input wire logic [7:0] O_RDATA,
   // events and outputs
   input wire logic [1:0] I_WATCHDOG_MODE_SELECT,
   input wire logic       I_WATCHDOG_CLEAR_INSTRUCTION,
   input wire logic       I_SLEEP_INSTRUCTION,
   input wire logic       I_OSC_FAIL,
   input wire logic       O_WDT_RESET,
   input wire logic       O_WDT_WAKE,
   input wire logic       O_ASLEEP
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SRST);
   wire logic expiry = O_WDT_RESET | O_WDT_WAKE;
   // two held cycles so an expiry already in flight cannot slip through
   sequence s_held_clear; I_WATCHDOG_CLEAR_INSTRUCTION [*2]; endsequence
   sequence s_held_fail; I_OSC_FAIL [*2]; endsequence
   a_pulse_single: assert property (expiry |=> !expiry) else $error("long time-out");
   a_off_quiet: assert property ((I_WATCHDOG_MODE_SELECT == 2'h0) [*2] |-> !expiry)
      else $error("time-out while off");
   a_no_sleep_wake: assert property ((I_WATCHDOG_MODE_SELECT == 2'h2) [*2] |-> !O_WDT_WAKE)
      else $error("wake in off-in-sleep mode");
   a_reset_awake: assert property (O_WDT_RESET |-> !$past(O_ASLEEP)) else $error("reset asleep");
   a_wake_asleep: assert property (O_WDT_WAKE |-> $past(O_ASLEEP)) else $error("wake awake");
   a_clear_restarts: assert property (s_held_clear |=> !expiry) else $error("clear ignored");
   a_fail_restarts: assert property (s_held_fail |=> !expiry) else $error("fail ignored");
   a_sleep_entry: assert property (I_SLEEP_INSTRUCTION && !O_ASLEEP |=> O_ASLEEP)
      else $error("sleep not entered");
   a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00) else $error("stray data");
   a_ctrl_top_zero: assert property ($past(I_RD) && $past(I_ADDR) == 4'h0 |-> O_RDATA[7:6] == 2'h0)
      else $error("control top bits set");
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking testbench for the watchdog timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   logic       clk = 0, srst = 1, wr_s = 0, rd_s = 0, wake_ev = 0, osc_fail = 0;
   logic [2:0] ev = 0;
   logic [3:0] addr = 0, div = 0;
   logic [7:0] wdata = 0, rv;
   logic [1:0] mode = 2'h3;
   wire logic [7:0] rdata;
   wire logic  rst_o, wake_o, asleep;
   int         num_errors = 0, total_checks = 0, cyc = 0, n, e;
   always #5 clk = ~clk;
   watchdog_timer #(.TICK_CYCLES(2)) DUT (.I_CLK_SYS(clk), .I_SRST(srst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_WATCHDOG_MODE_SELECT(mode),
      .I_WATCHDOG_CLEAR_INSTRUCTION(ev[0]), .I_SLEEP_INSTRUCTION(ev[1]), .I_WAKE_EVENT(ev[2]),
      .I_OSC_FAIL(osc_fail), .I_INTERNAL_OSC_DIVIDER(div), .O_WDT_RESET(rst_o), .O_WDT_WAKE(wake_o),
      .O_ASLEEP(asleep));
   task end_of_test;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         end_of_test;
      end
   end
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      {addr, wdata, wr_s} <= {a, d, 1'b1};
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk);
      {addr, rd_s} <= {a, 1'b1};
      @(posedge clk);
      rd_s <= 1'b0;
      #1 rv = rdata;
   endtask
   task pulse(input logic [2:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 3'h0;
   endtask
   // bounded wait for either time-out pulse; n returns the cycles spent
   // outputs looked at 1 ns after the edge, once they have settled
   task wait_evt(input int lim);
      n = 0;
      #1;
      while (!(rst_o | wake_o) && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task t_reset_values;
      rd(4'h0);
      `CHK(rv, 8'h16)
      rd(4'hF);
      `CHK(rv, 8'h00)
      wr(4'h0, 8'hFF);
      rd(4'h0);
      `CHK(rv, 8'h3F)
   endtask
   task t_period;
      logic [4:0] sel [4] = '{5'h00, 5'h01, 5'h13, 5'h1F};
      foreach (sel[i]) begin
         wr(4'h0, {2'h0, sel[i], 1'b0});
         pulse(3'h1);
         div <= div + 4'h5;
         e = (sel[i] > 5'h12) ? 64 : 2 << (5 + sel[i]);
         wait_evt(300);
         `CHK(rst_o, 1'b1)
         `CHK(n >= e - 4 && n <= e + 4, 1'b1)
      end
      rd(4'h2);
      `CHK(rv[4], 1'b0)
   endtask
   task t_modes;
      mode <= 2'h0;
      wr(4'h0, 8'h01);
      wait_evt(200);
      `CHK(n, 200)
      {mode, wdata} <= {2'h1, 8'h00};
      wr(4'h0, 8'h00);
      wait_evt(200);
      `CHK(n, 200)
      wr(4'h0, 8'h01);
      wait_evt(200);
      `CHK(rst_o, 1'b1)
      mode <= 2'h2;
      pulse(3'h2);
      wait_evt(200);
      `CHK({n, asleep}, {32'd200, 1'b1})
      pulse(3'h4);
      mode <= 2'h3;
      wr(4'h3, 8'h02);
      wait_evt(200);
      `CHK({rst_o, wake_o}, 2'h1)
      rd(4'h1);
      `CHK(rv & 8'h18, 8'h00)
   endtask
   // clear held, then oscillator failure held: count pinned at zero, then a time-out
   task t_hold;
      wr(4'h0, 8'h00);
      @(posedge clk);
      ev <= 3'h1;
      wait_evt(200);
      `CHK(n, 200)
      {ev, osc_fail} <= {3'h0, 1'b1};
      wait_evt(200);
      `CHK(n, 200)
      osc_fail <= 1'b0;
      wait_evt(200);
      `CHK(rst_o, 1'b1)
   endtask
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_reset_values;
      t_period;
      t_modes;
      t_hold;
      end_of_test;
   end
endmodule
bind watchdog_timer watchdog_timer_asserts u_chk (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST),
   .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_WATCHDOG_MODE_SELECT(I_WATCHDOG_MODE_SELECT),
   .I_WATCHDOG_CLEAR_INSTRUCTION(I_WATCHDOG_CLEAR_INSTRUCTION), .I_OSC_FAIL(I_OSC_FAIL),
   .I_SLEEP_INSTRUCTION(I_SLEEP_INSTRUCTION), .O_WDT_RESET(O_WDT_RESET), .O_WDT_WAKE(O_WDT_WAKE),
   .O_ASLEEP(O_ASLEEP));
`default_nettype wire
